// ---- sysref_clk_consts.svh ----
// Purpose: Offsets, field positions and reset values of the clock/SYSREF register bank
// Assumes: Byte-wide register port, one byte per address, wide registers little endian
// Notes: Definitions only
`ifndef SYSREF_CLK_CONSTS_SVH
`define SYSREF_CLK_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 8
`define POS_W 24

`define CTL_ADDR 8'h2a
`define TUNE_ADDR 8'h2b
`define POS_ADDR0 8'h2c
`define POS_ADDR1 8'h2d
`define POS_ADDR2 8'h2e

`define CTL_RESET 8'h00
`define TUNE_RESET 8'h11
`define POS_RESET 24'h00_0000
`define RDATA_IDLE 8'h00

`define CTL_MARKER_BIT 3
`define CTL_DEVCLK_DC_BIT 2
`define CTL_SYSREF_DC_BIT 1
`define CTL_INVERT_BIT 0
`define TUNE_GAIN_BIT 4
`define TUNE_NOISE_BIT 2
`define TUNE_DELAY_HI 1
`define TUNE_DELAY_LO 0

`define POS_BYTE1_LO 8
`define POS_BYTE2_LO 16

`endif

// ---- sysref_clk_pkg.sv ----
// Purpose: Types shared by the clock/SYSREF register bank
// Assumes: Constants header holds all numbers
// Notes: Packed structs carry the register port and the analog controls
package sysref_clk_pkg;
    `include "sysref_clk_consts.svh"

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic rvalid;
        logic [`DATA_W-1:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic device_clock_dc_coupled_mode;
        logic sysref_dc_coupled_mode;
        logic sysref_polarity_invert;
        logic feedback_gain_high;
        logic analog_supply_noise_suppress;
        logic [1:0] sampling_clock_delay_select;
    } clk_controls_t;
endpackage : sysref_clk_pkg

// ---- sysref_position_capture.sv ----
// Purpose: Synchronise SYSREF and its phase taps, apply polarity, capture edge position
// Assumes: sysref and taps arrive asynchronously to mclk
// Notes: A level counts once the second and third stages agree
`timescale 1ns/1ns
`include "sysref_clk_consts.svh"
module sysref_position_capture
    import sysref_clk_pkg::*;
#(
    parameter int TAP_W = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sysref,
    input wire logic [TAP_W-1:0] sysref_phase_taps,
    input wire logic invert,
    output logic sysref_aligned,
    output logic [TAP_W-1:0] position,
    output logic captured
);
    initial begin
        if (TAP_W < 1) $error("TAP_W must be positive");
    end

    logic [2:0] ref_sync;
    logic [TAP_W-1:0] tap_s1, tap_s2, tap_s3;
    logic ref_level;
    logic aligned_q;
    wire ref_agree = (ref_sync[1] == ref_sync[2]);
    wire next_aligned = ref_level ^ invert;
    wire edge_seen = next_aligned & ~aligned_q;

    always_ff @(posedge mclk) begin
        ref_sync <= {ref_sync[1:0], sysref};
        tap_s1 <= sysref_phase_taps;
        tap_s2 <= tap_s1;
        tap_s3 <= tap_s2;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_level <= 1'b0;
            aligned_q <= 1'b0;
            position <= TAP_W'(`POS_RESET);
            captured <= 1'b0;
        end else begin
            if (ref_agree) ref_level <= ref_sync[2];
            aligned_q <= next_aligned; // [R6]
            if (edge_seen) begin
                position <= tap_s3; // [R12]
                captured <= 1'b1;
            end
        end
    end

    assign sysref_aligned = aligned_q;

    AST_INVERT: assert property (@(posedge mclk) disable iff (rst)
        ##1 aligned_q == ($past(ref_level) ^ $past(invert))) // [R6]
        else $error("aligned SYSREF does not follow polarity control");
    AST_CAPTURE: assert property (@(posedge mclk) disable iff (rst)
        edge_seen |=> position == $past(tap_s3) && captured) // [R12]
        else $error("edge position not captured");
endmodule : sysref_position_capture

// ---- sysref_clock_control_regs.sv ----
// Purpose: Clock and SYSREF input control registers with SYSREF capture position status
// Assumes: Byte register port behind the configuration serial port, mclk domain
// Notes: Read data appears one cycle after the read strobe
// How it works
// [R1] Input control register at 0x2A, resets zero
// [R2] Both marker enables put SYSREF on LSB
// [R3] Host uses marker only with decimation one
// [R4] Bit 2 selects DC-coupled clock input
// [R5] Bit 1 selects DC-coupled SYSREF input
// [R6] Bit 0 inverts SYSREF before alignment
// [R7] Tuning register at 0x2B, resets 0x11
// [R8] Bit 4 high feedback gain, resets 1
// [R9] Bit 2 enables analog supply noise suppression
// [R10] Bits 1:0 one-hot sampling delay, reset 1
// [R11] 24-bit read-only capture position at 0x2C
// [R12] Position reports SYSREF edge versus clock
// [R13] Reserved bits store; position writes ignored
`timescale 1ns/1ns
`include "sysref_clk_consts.svh"
module sysref_clock_control_regs
    import sysref_clk_pkg::*;
#(
    parameter int SAMPLE_W = 12,
    parameter int TAP_W = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_t req,
    output reg_rsp_t rsp,
    input wire logic sysref,
    input wire logic [TAP_W-1:0] sysref_phase_taps,
    input wire logic sample_marker_enable,
    input wire logic [SAMPLE_W-1:0] sample_in,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic sysref_marker_active,
    output clk_controls_t controls
);
    initial begin
        if (TAP_W != `POS_W) $error("TAP_W must match the position register width");
        if (SAMPLE_W < 2) $error("SAMPLE_W must be at least 2");
    end

    function automatic logic addr_hit(input logic [`ADDR_W-1:0] a,
                                      input logic [`ADDR_W-1:0] b);
        addr_hit = (a == b);
    endfunction : addr_hit

    logic [`DATA_W-1:0] sysref_clock_input_control;
    logic [`DATA_W-1:0] sampling_clock_tuning;
    logic [TAP_W-1:0] sysref_capture_position;
    logic captured;
    logic sysref_aligned;
    logic [`DATA_W-1:0] rdata_q;
    logic rvalid_q;

    // Address decode
    wire hit_ctl = addr_hit(req.addr, `CTL_ADDR);
    wire hit_tune = addr_hit(req.addr, `TUNE_ADDR);
    wire hit_pos0 = addr_hit(req.addr, `POS_ADDR0);
    wire hit_pos1 = addr_hit(req.addr, `POS_ADDR1);
    wire hit_pos2 = addr_hit(req.addr, `POS_ADDR2);
    wire wr_ctl = req.wr & hit_ctl;
    wire wr_tune = req.wr & hit_tune;

    // Read selection; unmapped bytes read as zero
    wire [`DATA_W-1:0] pos_b0 = sysref_capture_position[`POS_BYTE1_LO-1:0];
    wire [`DATA_W-1:0] pos_b1 = sysref_capture_position[`POS_BYTE2_LO-1:`POS_BYTE1_LO];
    wire [`DATA_W-1:0] pos_b2 = sysref_capture_position[`POS_W-1:`POS_BYTE2_LO];
    wire [`DATA_W-1:0] next_rdata =
        hit_ctl  ? sysref_clock_input_control :
        hit_tune ? sampling_clock_tuning :
        hit_pos0 ? pos_b0 :
        hit_pos1 ? pos_b1 :
        hit_pos2 ? pos_b2 : `RDATA_IDLE;

    // Timestamp marker selection
    wire marker_sel = sysref_clock_input_control[`CTL_MARKER_BIT] & sample_marker_enable;
    wire [SAMPLE_W-1:0] next_sample =
        marker_sel ? {sample_in[SAMPLE_W-1:1], sysref_aligned} : sample_in;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sysref_clock_input_control <= `CTL_RESET; // [R1]
        end else if (wr_ctl) begin
            sysref_clock_input_control <= req.wdata; // [R13]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sampling_clock_tuning <= `TUNE_RESET; // [R7] [R8] [R10]
        end else if (wr_tune) begin
            sampling_clock_tuning <= req.wdata; // [R13]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= `RDATA_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) rdata_q <= next_rdata; // [R11]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sample_out <= '0;
            sysref_marker_active <= 1'b0;
        end else begin
            sample_out <= next_sample; // [R2]
            sysref_marker_active <= marker_sel; // [R2]
        end
    end

    // Position register is written only by the capture logic
    sysref_position_capture #(
        .TAP_W(TAP_W)
    ) u_capture (
        .mclk(mclk),
        .rst(rst),
        .sysref(sysref),
        .sysref_phase_taps(sysref_phase_taps),
        .invert(sysref_clock_input_control[`CTL_INVERT_BIT]), // [R6]
        .sysref_aligned(sysref_aligned),
        .position(sysref_capture_position), // [R11] [R12]
        .captured(captured)
    );

    assign rsp.rvalid = rvalid_q;
    assign rsp.rdata = rdata_q;

    // Analog control outputs come straight from register bits
    assign controls.device_clock_dc_coupled_mode =
        sysref_clock_input_control[`CTL_DEVCLK_DC_BIT]; // [R4]
    assign controls.sysref_dc_coupled_mode =
        sysref_clock_input_control[`CTL_SYSREF_DC_BIT]; // [R5]
    assign controls.sysref_polarity_invert =
        sysref_clock_input_control[`CTL_INVERT_BIT]; // [R6]
    assign controls.feedback_gain_high = sampling_clock_tuning[`TUNE_GAIN_BIT]; // [R8]
    assign controls.analog_supply_noise_suppress =
        sampling_clock_tuning[`TUNE_NOISE_BIT]; // [R9]
    assign controls.sampling_clock_delay_select =
        sampling_clock_tuning[`TUNE_DELAY_HI:`TUNE_DELAY_LO]; // [R10]

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_CTL_RESET: assert property ( // [R1]
        $fell(rst) |-> sysref_clock_input_control == `CTL_RESET)
        else $error("input control register not zero after reset");
    AST_MARKER: assert property ( // [R2]
        sysref_clock_input_control[`CTL_MARKER_BIT] && sample_marker_enable
        |=> sample_out[0] == $past(sysref_aligned) && sysref_marker_active)
        else $error("SYSREF not on sample LSB while marker enabled");
    AST_NO_MARKER: assert property ( // [R2]
        !sample_marker_enable |=> sample_out == $past(sample_in) && !sysref_marker_active)
        else $error("sample altered without marker enable");
    AST_DEVCLK: assert property ( // [R4]
        wr_ctl |=> controls.device_clock_dc_coupled_mode == $past(req.wdata[2]))
        else $error("clock input mode does not follow control bit");
    AST_SYSREF_MODE: assert property ( // [R5]
        wr_ctl |=> controls.sysref_dc_coupled_mode == $past(req.wdata[1]))
        else $error("SYSREF input mode does not follow control bit");
    AST_TUNE_RESET: assert property ( // [R7]
        $fell(rst) |-> sampling_clock_tuning == `TUNE_RESET
                       && controls.feedback_gain_high
                       && controls.sampling_clock_delay_select == 2'h1)
        else $error("tuning register not 0x11 after reset");
    AST_GAIN: assert property ( // [R8]
        wr_tune ##1 !wr_tune |-> controls.feedback_gain_high == $past(req.wdata[`TUNE_GAIN_BIT]))
        else $error("feedback gain does not follow tuning bit");
    AST_NOISE: assert property ( // [R9]
        wr_tune |=> controls.analog_supply_noise_suppress == $past(req.wdata[2]))
        else $error("noise suppression does not follow tuning bit");
    AST_DELAY: assert property ( // [R10]
        wr_tune |=> controls.sampling_clock_delay_select == $past(req.wdata[1:0]))
        else $error("sampling delay does not follow tuning bits");
    AST_POS_RO: assert property ( // [R11]
        req.wr && (hit_pos0 || hit_pos1 || hit_pos2)
        |=> $rose(sysref_aligned) || sysref_capture_position == $past(sysref_capture_position))
        else $error("write changed the read-only position register");
    AST_READBACK: assert property ( // [R13]
        req.rd && hit_ctl && !req.wr |=> rsp.rvalid && rsp.rdata == sysref_clock_input_control)
        else $error("control register read-back mismatch");
    AST_POS_READ: assert property ( // [R12]
        req.rd && hit_pos2 |=> rsp.rvalid && rsp.rdata == $past(pos_b2))
        else $error("position top byte read mismatch");
    AST_UNMAPPED: assert property ( // [R11]
        req.rd && !(hit_ctl || hit_tune || hit_pos0 || hit_pos1 || hit_pos2)
        |=> rsp.rvalid && rsp.rdata == `RDATA_IDLE)
        else $error("unmapped address did not read zero");

    // Register storage and hold
    AST_CTL_WRITE: assert property ( // [R1]
        wr_ctl
        |=> sysref_clock_input_control == $past(req.wdata))
        else $error("input control register did not take written byte");

    AST_TUNE_WRITE: assert property ( // [R7]
        wr_tune
        |=> sampling_clock_tuning == $past(req.wdata))
        else $error("tuning register did not take written byte");

    AST_CTL_HOLD: assert property ( // [R13]
        !wr_ctl
        |=> $stable(sysref_clock_input_control))
        else $error("input control register changed without a write");

    AST_TUNE_HOLD: assert property ( // [R13]
        !wr_tune
        |=> $stable(sampling_clock_tuning))
        else $error("tuning register changed without a write");

    AST_UNMAPPED_WR: assert property ( // [R13]
        req.wr && !(hit_ctl || hit_tune)
        |=> $stable(sysref_clock_input_control) && $stable(sampling_clock_tuning))
        else $error("write to another address changed a control register");

    AST_INVERT_CTL: assert property ( // [R6]
        wr_ctl
        |=> controls.sysref_polarity_invert == $past(req.wdata[`CTL_INVERT_BIT]))
        else $error("polarity control does not follow control bit");

    AST_GAIN_WRITE: assert property ( // [R8]
        wr_tune
        |=> controls.feedback_gain_high == $past(req.wdata[`TUNE_GAIN_BIT]))
        else $error("feedback gain not updated by tuning write");

    // Read port
    AST_NO_READ: assert property ( // [R11]
        !req.rd
        |=> !rsp.rvalid)
        else $error("read answer without a read strobe");

    AST_RDATA_HOLD: assert property ( // [R11]
        !req.rd
        |=> $stable(rsp.rdata))
        else $error("read data changed without a read strobe");

    AST_TUNE_READ: assert property ( // [R7]
        req.rd && hit_tune && !req.wr
        |=> rsp.rvalid && rsp.rdata == sampling_clock_tuning)
        else $error("tuning register read-back mismatch");

    AST_POS_READ0: assert property ( // [R11]
        req.rd && hit_pos0
        |=> rsp.rvalid && rsp.rdata == $past(pos_b0))
        else $error("position low byte read mismatch");

    AST_POS_READ1: assert property ( // [R11]
        req.rd && hit_pos1
        |=> rsp.rvalid && rsp.rdata == $past(pos_b1))
        else $error("position middle byte read mismatch");

    AST_READ_OLD: assert property ( // [R13]
        req.rd && req.wr && hit_ctl
        |=> rsp.rdata == $past(sysref_clock_input_control))
        else $error("read beside a write did not return the old value");

    // Sample marker
    AST_MARKER_OFF: assert property ( // [R2]
        !sysref_clock_input_control[`CTL_MARKER_BIT]
        |=> sample_out == $past(sample_in) && !sysref_marker_active)
        else $error("sample altered while marker insertion is off");

    AST_SAMPLE_UPPER: assert property ( // [R2]
        1'b1
        |=> sample_out[SAMPLE_W-1:1] == $past(sample_in[SAMPLE_W-1:1]))
        else $error("upper sample bits not passed through");

    // Values after reset and capture position
    AST_RSP_RESET: assert property ( // [R11]
        $fell(rst)
        |-> !rsp.rvalid && rsp.rdata == `RDATA_IDLE)
        else $error("read port not idle after reset");

    AST_SAMPLE_RESET: assert property ( // [R2]
        $fell(rst)
        |-> sample_out == '0 && !sysref_marker_active)
        else $error("sample output not cleared by reset");

    AST_POS_RESET: assert property ( // [R11]
        $fell(rst)
        |-> sysref_capture_position == `POS_RESET)
        else $error("capture position not cleared by reset");

    AST_POS_STABLE: assert property ( // [R12]
        !$rose(sysref_aligned)
        |-> $stable(sysref_capture_position))
        else $error("capture position changed without a SYSREF edge");

    AST_POS_CAPTURED: assert property ( // [R12]
        $rose(sysref_aligned)
        |-> captured)
        else $error("SYSREF edge not marked as captured");

    COV_MARKER: cover property (marker_sel ##1 sysref_marker_active);
    COV_CAPTURE: cover property ($rose(captured));
    COV_TUNE_WRITE: cover property (wr_tune ##2 req.rd && hit_tune);
    COV_POS_WRITE: cover property (req.wr && hit_pos0);
    COV_INVERT: cover property (controls.sysref_polarity_invert && $rose(sysref_aligned));
endmodule : sysref_clock_control_regs

// ---- sysref_source.sv ----
// Purpose: SYSREF level and delay-line tap source facing the clock register bank
// Assumes: Changes land just after rising mclk edges
// Notes: Taps are set well before each SYSREF edge and held after it
`timescale 1ns/1ns
module sysref_source (
    input wire logic mclk,
    output logic sysref,
    output logic [23:0] taps
);
    initial begin
        sysref = 1'b0;
        taps = 24'h000000;
    end

    // Taps stay steady across the edge so the captured position is meaningful
    task automatic edge_to(input logic lvl, input logic [23:0] t);
        @(posedge mclk);
        taps <= t;
        repeat (4) @(posedge mclk);
        sysref <= lvl;
        repeat (10) @(posedge mclk);
    endtask : edge_to
endmodule : sysref_source

// ---- sysref_clock_control_regs_tb_top.sv ----
// Purpose: Self-checking bench for the clock and SYSREF register bank
// Assumes: Byte register port, read answer one cycle after the strobe
// Notes: Random register values from a fixed seed, corner cases mixed in
`timescale 1ns/1ns
`include "sysref_clk_consts.svh"
module sysref_clock_control_regs_tb_top
    import sysref_clk_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    reg_rsp_t rsp;
    logic marker_en = 1'b0;
    logic [11:0] sample_in = 12'h000;
    logic [11:0] sample_out;
    logic marker_active;
    clk_controls_t controls;
    logic sysref;
    logic [23:0] taps;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] rd_val;
    logic [7:0] c;
    logic [7:0] t;
    logic [11:0] s;
    logic [23:0] p1;
    logic [23:0] p2;
    logic [23:0] pos;

    always #2 mclk = ~mclk;

    sysref_source src (.mclk(mclk), .sysref(sysref), .taps(taps));

    sysref_clock_control_regs uut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp),
        .sysref(sysref), .sysref_phase_taps(taps), .sample_marker_enable(marker_en),
        .sample_in(sample_in), .sample_out(sample_out),
        .sysref_marker_active(marker_active), .controls(controls));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        req <= '0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        req <= '0;
        #1;
        d = (rsp.rvalid === 1'b1) ? rsp.rdata : 8'hxx;
    endtask : rd_reg

    task automatic read_pos(output logic [23:0] p);
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        rd_reg(`POS_ADDR0, b0);
        rd_reg(`POS_ADDR1, b1);
        rd_reg(`POS_ADDR2, b2);
        p = {b2, b1, b0};
    endtask : read_pos

    function automatic clk_controls_t exp_ctl(input logic [7:0] cv, input logic [7:0] tv);
        return '{cv[2], cv[1], cv[0], tv[4], tv[2], tv[1:0]};
    endfunction : exp_ctl

    task automatic conclude();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        #40000;
        failures++;
        conclude();
    end

    initial begin
        void'($urandom(32'h7c78));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(`CTL_ADDR, rd_val);
        check(rd_val, 8'h00);
        rd_reg(`TUNE_ADDR, rd_val);
        check(rd_val, 8'h11);
        check(controls, exp_ctl(8'h00, 8'h11));
        for (int i = 0; i < 8; i++) begin
            c = 8'($urandom);
            t = {6'($urandom), (i % 2 == 1) ? 2'b10 : 2'b01};
            if (i == 0) begin
                c = 8'hff;
                t = 8'hee;
            end
            wr_reg(`CTL_ADDR, c);
            wr_reg(`TUNE_ADDR, t);
            rd_reg(`CTL_ADDR, rd_val);
            check(rd_val, c);
            rd_reg(`TUNE_ADDR, rd_val);
            check(rd_val, t);
            check(controls, exp_ctl(c, t));
        end
        wr_reg(8'h2f, 8'h5a);
        rd_reg(8'h2f, rd_val);
        check(rd_val, 8'h00);
        wr_reg(`CTL_ADDR, 8'h00);
        p1 = 24'($urandom);
        p2 = ~p1;
        src.edge_to(1'b1, p1);
        read_pos(pos);
        check(pos, p1);
        wr_reg(`POS_ADDR1, 8'h5a);
        wr_reg(`POS_ADDR0, 8'ha5);
        read_pos(pos);
        check(pos, p1);
        // Marker modes: ctl bit3 and enable, only both together mark the LSB
        for (int m = 0; m < 3; m++) begin
            wr_reg(`CTL_ADDR, (m == 2) ? 8'h00 : 8'h08);
            @(posedge mclk);
            marker_en <= (m != 0);
            repeat (3) @(posedge mclk);
            #1;
            check(marker_active, (m == 1));
            for (int k = 0; k < 4; k++) begin
                s = 12'($urandom);
                @(posedge mclk);
                sample_in <= s;
                @(posedge mclk);
                #1;
                check(sample_out, {s[11:1], (m == 1) ? 1'b1 : s[0]});
            end
        end
        wr_reg(`CTL_ADDR, 8'h01);
        src.edge_to(1'b0, p2);
        read_pos(pos);
        check(pos, p2);
        conclude();
    end
endmodule : sysref_clock_control_regs_tb_top
